// ==== logic/bmc_uart_regs.sv ====
// UART hex register access interpreter with fan control.
// Assumes rx_pin is asynchronous; fan_rpm and cpu_temp share ref_clk.
// What this block does
// - First byte: upper seven bits address, bit zero one for read.
// - Second byte gives number of register bytes to transfer.
// - On read, controller returns one byte per counted register byte.
// - Controller returns each byte as two ASCII hex characters.
// - Multi-byte registers return least significant byte first.
// - Link runs 115200 baud, 8 data, even parity, 1 stop.
// - A boot stage runs first after reset, then the application.
// - Jumper fitted: temperature fan control; removed: full speed.
// - Writing 02 to address 0F clears latched system faults.
// - Address 04 holds 16-bit fan speed in RPM, two bytes.
// - Address 06 holds fan speed fault status, one byte.
// - Mezzanine faults latch after detection; cleared only by reset.
`timescale 1ns/1ps
`default_nettype none
module bmc_uart_regs #(
  parameter int BIT_CYC = bmc_pkg::BIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire logic fan_mode_jumper,
  input wire logic [7:0] cpu_temp,
  input wire logic [15:0] fan_rpm,
  input wire logic fan_fault_event,
  input wire logic [15:0] mezz_fault_in,
  input wire logic card_detect_done,
  output logic fan_pwm,
  output logic app_running,
  output logic [7:0] fan_fault_flags
);
  // ------------------------------------------------------------------
  // Input synchronisers: change taken when stages two and three agree
  // ------------------------------------------------------------------
  logic [2:0] rx_sync_reg, rx_sync_next;
  logic [2:0] jp_sync_reg, jp_sync_next;
  logic rx_reg, rx_next, jp_reg, jp_next;
  always_comb begin
    rx_sync_next = {rx_sync_reg[1:0], rx_pin};
    jp_sync_next = {jp_sync_reg[1:0], fan_mode_jumper};
    rx_next = (rx_sync_reg[1] == rx_sync_reg[2]) ? rx_sync_reg[2] : rx_reg;
    jp_next = (jp_sync_reg[1] == jp_sync_reg[2]) ? jp_sync_reg[2] : jp_reg;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_sync_reg <= 3'h7;
      jp_sync_reg <= 3'h0;
      rx_reg <= 1'b1;
      jp_reg <= 1'b0;
    end else begin
      rx_sync_reg <= rx_sync_next;
      jp_sync_reg <= jp_sync_next;
      rx_reg <= rx_next;
      jp_reg <= jp_next;
    end
  end

  // ------------------------------------------------------------------
  // UART receiver, 8E1; bad parity frames are dropped
  // ------------------------------------------------------------------
  logic [15:0] rx_cnt_reg, rx_cnt_next;
  logic [3:0] rx_bit_reg, rx_bit_next;
  logic [8:0] rx_sh_reg, rx_sh_next;
  logic rx_busy_reg, rx_busy_next, rx_vld_reg, rx_vld_next;
  always_comb begin
    rx_cnt_next = rx_cnt_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    rx_busy_next = rx_busy_reg;
    rx_vld_next = 1'b0;
    if (!rx_busy_reg) begin
      if (!rx_reg) begin
        rx_busy_next = 1'b1;
        rx_cnt_next = 16'(BIT_CYC / 2);
        rx_bit_next = 4'h0;
      end
    end else if (rx_cnt_reg != 16'h0) begin
      rx_cnt_next = rx_cnt_reg - 16'h1;
    end else begin
      rx_cnt_next = 16'(BIT_CYC - 1);
      rx_bit_next = rx_bit_reg + 4'h1;
      if (rx_bit_reg == 4'h0 && rx_reg) begin
        rx_busy_next = 1'b0; // False start
      end else if (rx_bit_reg >= 4'h1 && rx_bit_reg <= 4'h9) begin
        rx_sh_next = {rx_reg, rx_sh_reg[8:1]};
      end else if (rx_bit_reg == 4'ha) begin
        rx_busy_next = 1'b0;
        rx_vld_next = rx_reg && !(^rx_sh_reg);
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_cnt_reg <= 16'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 9'h0;
      rx_busy_reg <= 1'b0;
      rx_vld_reg <= 1'b0;
    end else begin
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg <= rx_sh_next;
      rx_busy_reg <= rx_busy_next;
      rx_vld_reg <= rx_vld_next;
    end
  end
  wire logic [7:0] rx_char = rx_sh_reg[7:0];

  // ASCII hex to nibble; flag marks a valid hex digit
  function automatic logic [4:0] hex2nib(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, 4'(c - 8'h30)};
    else if (c >= 8'h41 && c <= 8'h46) return {1'b1, 4'(c - 8'h37)};
    else if (c >= 8'h61 && c <= 8'h66) return {1'b1, 4'(c - 8'h57)};
    else return 5'h00;
  endfunction
  function automatic logic [7:0] nib2hex(input logic [3:0] n);
    return (n < 4'ha) ? 8'(8'h30 + n) : 8'(8'h37 + n);
  endfunction

  // ------------------------------------------------------------------
  // Register read mux; unmapped addresses read zero
  // ------------------------------------------------------------------
  logic [15:0] mezz_reg, mezz_next;
  logic mezz_done_reg, mezz_done_next;
  logic [7:0] fault_reg, fault_next;
  function automatic logic [7:0] reg_rd(input logic [6:0] a,
      input logic [15:0] rpm, input logic [7:0] ff,
      input logic [15:0] mz);
    case (a)
      bmc_pkg::ADDR_FAN_SPEED: return rpm[7:0];
      bmc_pkg::ADDR_FAN_SPEED + 7'h1: return rpm[15:8];
      bmc_pkg::ADDR_FAN_FAULT: return ff;
      bmc_pkg::ADDR_MEZZ_FAULT1: return mz[7:0];
      bmc_pkg::ADDR_MEZZ_FAULT2: return mz[15:8];
      default: return 8'h00;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Command interpreter
  // ------------------------------------------------------------------
  bmc_pkg::bmc_state_e st_reg, st_next;
  bmc_pkg::bmc_cmd_s cmd_reg, cmd_next;
  logic [3:0] hi_reg, hi_next;
  logic half_reg, half_next;
  logic [15:0] boot_reg, boot_next;
  logic [7:0] tx_byte_reg, tx_byte_next;
  logic tx_go, tx_busy, clr_go;
  logic [1:0] tx_ph_reg, tx_ph_next;
  logic [4:0] nib;
  logic [7:0] full_byte;
  logic [7:0] rd_val;
  always_comb begin
    st_next = st_reg;
    cmd_next = cmd_reg;
    hi_next = hi_reg;
    half_next = half_reg;
    boot_next = boot_reg;
    tx_byte_next = tx_byte_reg;
    tx_ph_next = tx_ph_reg;
    tx_go = 1'b0;
    clr_go = 1'b0;
    nib = hex2nib(rx_char);
    full_byte = {hi_reg, nib[3:0]};
    rd_val = reg_rd(cmd_reg.addr, fan_rpm, fault_reg, mezz_reg);
    case (st_reg)
      bmc_pkg::ST_BOOT: begin
        boot_next = boot_reg + 16'h1;
        if (boot_reg == 16'(bmc_pkg::BOOT_CYCLES)) st_next = bmc_pkg::ST_ADDR;
      end
      bmc_pkg::ST_ADDR, bmc_pkg::ST_COUNT, bmc_pkg::ST_DATA: begin
        if (rx_vld_reg && nib[4]) begin
          half_next = !half_reg;
          hi_next = nib[3:0];
          if (half_reg) begin
            if (st_reg == bmc_pkg::ST_ADDR) begin
              cmd_next.addr = full_byte[7:1];
              cmd_next.rd = full_byte[0];
              st_next = bmc_pkg::ST_COUNT;
            end else if (st_reg == bmc_pkg::ST_COUNT) begin
              cmd_next.count = full_byte;
              if (full_byte == 8'h00) st_next = bmc_pkg::ST_LF;
              else if (cmd_reg.rd) begin
                st_next = bmc_pkg::ST_SEND;
                tx_ph_next = 2'h0;
              end else st_next = bmc_pkg::ST_DATA;
            end else begin
              if (cmd_reg.addr == bmc_pkg::ADDR_FAULT_CLEAR &&
                  full_byte == bmc_pkg::FAULT_CLEAR_CODE)
                clr_go = 1'b1;
              cmd_next.addr = cmd_reg.addr + 7'h1;
              cmd_next.count = cmd_reg.count - 8'h1;
              if (cmd_reg.count == 8'h1) st_next = bmc_pkg::ST_LF;
            end
          end
        end
      end
      bmc_pkg::ST_SEND: begin
        if (!tx_busy && !tx_go) begin
          tx_go = 1'b1;
          tx_byte_next = (tx_ph_reg == 2'h0) ? nib2hex(rd_val[7:4]) :
            nib2hex(rd_val[3:0]);
          tx_ph_next = tx_ph_reg + 2'h1;
          if (tx_ph_reg == 2'h1) begin
            tx_ph_next = 2'h0;
            cmd_next.addr = cmd_reg.addr + 7'h1;
            cmd_next.count = cmd_reg.count - 8'h1;
            if (cmd_reg.count == 8'h1) st_next = bmc_pkg::ST_LF;
          end
        end
      end
      bmc_pkg::ST_LF: begin
        half_next = 1'b0;
        if (rx_vld_reg && rx_char == bmc_pkg::ASCII_LF)
          st_next = bmc_pkg::ST_ADDR;
      end
      default: st_next = bmc_pkg::ST_BOOT;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_reg <= bmc_pkg::ST_BOOT;
      cmd_reg <= '0;
      hi_reg <= 4'h0;
      half_reg <= 1'b0;
      boot_reg <= 16'h0;
      tx_byte_reg <= 8'h0;
      tx_ph_reg <= 2'h0;
    end else begin
      st_reg <= st_next;
      cmd_reg <= cmd_next;
      hi_reg <= hi_next;
      half_reg <= half_next;
      boot_reg <= boot_next;
      tx_byte_reg <= tx_byte_next;
      tx_ph_reg <= tx_ph_next;
    end
  end

  // ------------------------------------------------------------------
  // UART transmitter, 8E1; frame loaded the cycle after tx_go
  // ------------------------------------------------------------------
  logic [10:0] tx_sh_reg, tx_sh_next;
  logic [15:0] tx_cnt_reg, tx_cnt_next;
  logic [3:0] tx_bit_reg, tx_bit_next;
  logic tx_busy_reg, tx_busy_next, tx_ld_reg, tx_ld_next;
  assign tx_busy = tx_busy_reg || tx_ld_reg;
  always_comb begin
    tx_sh_next = tx_sh_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_bit_next = tx_bit_reg;
    tx_busy_next = tx_busy_reg;
    tx_ld_next = tx_go;
    if (tx_ld_reg) begin
      tx_sh_next = {1'b1, ^tx_byte_reg, tx_byte_reg, 1'b0};
      tx_busy_next = 1'b1;
      tx_cnt_next = 16'(BIT_CYC - 1);
      tx_bit_next = 4'h0;
    end else if (tx_busy_reg) begin
      if (tx_cnt_reg != 16'h0) tx_cnt_next = tx_cnt_reg - 16'h1;
      else begin
        tx_cnt_next = 16'(BIT_CYC - 1);
        tx_sh_next = {1'b1, tx_sh_reg[10:1]};
        tx_bit_next = tx_bit_reg + 4'h1;
        if (tx_bit_reg == 4'ha) tx_busy_next = 1'b0;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_sh_reg <= 11'h7ff;
      tx_cnt_reg <= 16'h0;
      tx_bit_reg <= 4'h0;
      tx_busy_reg <= 1'b0;
      tx_ld_reg <= 1'b0;
    end else begin
      tx_sh_reg <= tx_sh_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_busy_reg <= tx_busy_next;
      tx_ld_reg <= tx_ld_next;
    end
  end
  assign tx_pin = tx_sh_reg[0];

  // ------------------------------------------------------------------
  // Faults: fan faults sticky, set beats clear; mezzanine latched once
  // ------------------------------------------------------------------
  always_comb begin
    fault_next = fault_reg;
    if (clr_go) fault_next = bmc_pkg::FAULT_RESET;
    if (fan_fault_event) fault_next[0] = 1'b1;
    mezz_next = mezz_reg;
    mezz_done_next = mezz_done_reg;
    if (card_detect_done && !mezz_done_reg) begin
      mezz_next = mezz_fault_in;
      mezz_done_next = 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fault_reg <= bmc_pkg::FAULT_RESET;
      mezz_reg <= 16'h0;
      mezz_done_reg <= 1'b0;
    end else begin
      fault_reg <= fault_next;
      mezz_reg <= mezz_next;
      mezz_done_reg <= mezz_done_next;
    end
  end
  assign fan_fault_flags = fault_reg;

  // ------------------------------------------------------------------
  // Fan PWM: jumper fitted tracks temperature, otherwise full speed
  // ------------------------------------------------------------------
  logic [7:0] pwm_cnt_reg, pwm_cnt_next;
  logic pwm_reg, pwm_next;
  always_comb begin
    pwm_cnt_next = pwm_cnt_reg + 8'h1;
    pwm_next = jp_reg ? (pwm_cnt_reg < cpu_temp) : 1'b1;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwm_cnt_reg <= 8'h0;
      pwm_reg <= 1'b1;
    end else begin
      pwm_cnt_reg <= pwm_cnt_next;
      pwm_reg <= pwm_next;
    end
  end
  assign fan_pwm = pwm_reg;
  assign app_running = (st_reg != bmc_pkg::ST_BOOT);
endmodule // bmc_uart_regs
`default_nettype wire

// ==== logic/bmc_pkg.sv ====
// Package for the board management UART register access block.
// Assumes a single 250 MHz clock and a UART line at 115200 8E1.
package bmc_pkg;
  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int CLK_HZ = 250000000;
  localparam int BAUD = 115200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD;
  localparam int FAN_PWM_CYCLES = 256;
  localparam int BOOT_NS = 1000;
  localparam int BOOT_CYCLES = (BOOT_NS + 3) / 4;
  // --------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------
  localparam logic [6:0] ADDR_FAN_SPEED = 7'h04;
  localparam logic [6:0] ADDR_FAN_FAULT = 7'h06;
  localparam logic [6:0] ADDR_FAULT_CLEAR = 7'h0f;
  localparam logic [6:0] ADDR_MEZZ_FAULT1 = 7'h70;
  localparam logic [6:0] ADDR_MEZZ_FAULT2 = 7'h71;
  localparam logic [7:0] FAULT_CLEAR_CODE = 8'h02;
  localparam logic [7:0] FAULT_RESET = 8'h00;
  localparam logic [7:0] ASCII_LF = 8'h0a;
  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_ADDR = 3'b001,
    ST_COUNT = 3'b011,
    ST_DATA = 3'b010,
    ST_SEND = 3'b110,
    ST_LF = 3'b111
  } bmc_state_e;
  typedef struct packed {
    logic [6:0] addr;
    logic rd;
    logic [7:0] count;
  } bmc_cmd_s;
endpackage

// ==== verif/bmc_uart_regs_monitor.sv ====
// Checker for the UART register access block, bound to its top module.
// Assumes one clock domain and a synchronous active low reset.
`timescale 1ns/1ps
`default_nettype none
module bmc_uart_regs_monitor #(
  parameter int BIT_CYC = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tx_pin,
  input wire logic fan_mode_jumper,
  input wire logic fan_fault_event,
  input wire logic fan_pwm,
  input wire logic app_running,
  input wire logic [7:0] fan_fault_flags
);
  // ------------------------------------------------------------------
  // Helper and assertions
  // ------------------------------------------------------------------
  localparam int MAX_LOW = 10 * BIT_CYC;
  logic [15:0] low_cnt_reg;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Length of the current low run on tx; a lost stop bit stretches it
  always_ff @(posedge ref_clk) begin
    if (!rst_n || tx_pin) low_cnt_reg <= 16'h0000;
    else low_cnt_reg <= low_cnt_reg + 16'h0001;
  end
  reset_values_a: assert property ($rose(rst_n) |-> tx_pin && fan_pwm &&
    !app_running && fan_fault_flags == 8'h00)
    else $error("outputs not at reset values");
  boot_hold_a: assert property ($rose(rst_n) |-> !app_running [*8])
    else $error("application started too early");
  boot_end_a: assert property ($rose(rst_n) |-> ##[245:255] app_running)
    else $error("boot stage did not end in time");
  app_stays_a: assert property (app_running |=> app_running)
    else $error("application stopped");
  boot_quiet_a: assert property (!app_running |-> tx_pin)
    else $error("transmit during boot stage");
  full_speed_a: assert property (!fan_mode_jumper [*6] |-> fan_pwm)
    else $error("fan not at full speed with jumper removed");
  fault_set_a: assert property (fan_fault_event && app_running |->
    ##[1:4] fan_fault_flags[0])
    else $error("fan fault not latched");
  start_bit_a: assert property ($fell(tx_pin) |-> !tx_pin [*8])
    else $error("start bit too short");
  stop_bit_a: assert property (low_cnt_reg <= MAX_LOW)
    else $error("transmit line low too long");
endmodule // bmc_uart_regs_monitor
bind bmc_uart_regs bmc_uart_regs_monitor #(.BIT_CYC(BIT_CYC)) mon (
  .ref_clk(ref_clk), .rst_n(rst_n), .tx_pin(tx_pin),
  .fan_mode_jumper(fan_mode_jumper), .fan_fault_event(fan_fault_event),
  .fan_pwm(fan_pwm), .app_running(app_running),
  .fan_fault_flags(fan_fault_flags));
`default_nettype wire

// ==== verif/bmc_host_model.sv ====
// Host end of the serial link: 8E1 sender of hex characters and a receiver.
// Assumes the bench calls the send tasks just after a falling edge.
`timescale 1ns/1ps
`default_nettype none
module bmc_host_model #(
  parameter int BIT_CYC = 16
) (
  input wire logic ref_clk,
  input wire logic tx_pin,
  output logic rx_pin
);
  // ------------------------------------------------------------------
  // Sender and receiver
  // ------------------------------------------------------------------
  logic [7:0] rx_q[$];
  int frame_err = 0;
  logic [7:0] d;
  initial rx_pin = 1'b1;
  // Upper case hex digit for a nibble
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
  endfunction
  // Start, data LSB first, even parity, stop; line idles high between
  task automatic send_char(input logic [7:0] c);
    logic [10:0] f;
    f = {1'b1, ^c, c, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_pin <= f[i];
      repeat (BIT_CYC) @(negedge ref_clk);
    end
  endtask
  // High nibble goes first
  task automatic send_byte(input logic [7:0] b);
    send_char(hex_char(b[7:4]));
    send_char(hex_char(b[3:0]));
  endtask
  // Mid-bit sampling; bad frames are counted, not dropped
  always begin
    @(negedge tx_pin);
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    if (tx_pin !== 1'b0) frame_err++;
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge ref_clk);
      d[i] = tx_pin;
    end
    repeat (BIT_CYC) @(posedge ref_clk);
    if (tx_pin !== ^d) frame_err++;
    repeat (BIT_CYC) @(posedge ref_clk);
    if (tx_pin !== 1'b1) frame_err++;
    rx_q.push_back(d);
  end
endmodule // bmc_host_model
`default_nettype wire

// ==== verif/bmc_uart_regs_tb.sv ====
// Self-checking bench: register reads and writes over the hex UART link.
// Assumes a shortened bit time; the post-read wait is scaled to match, the post-write wait is a fixed 200 cycles.
`timescale 1ns/1ps
`default_nettype none
module bmc_uart_regs_tb;
  // ------------------------------------------------------------------
  // Bench
  // ------------------------------------------------------------------
  localparam int BC = 16;
  localparam int CHAR = 11 * BC;
  localparam int WR_GAP = 200;
  logic ref_clk, rst_n, rx_pin, tx_pin, fan_mode_jumper, fan_fault_event;
  logic fan_pwm, app_running, card_detect_done;
  logic [7:0] cpu_temp, fan_fault_flags;
  logic [15:0] fan_rpm, mezz_fault_in;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int h0, h1;
  bmc_uart_regs #(.BIT_CYC(BC)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .fan_mode_jumper(fan_mode_jumper),
    .cpu_temp(cpu_temp), .fan_rpm(fan_rpm),
    .fan_fault_event(fan_fault_event), .mezz_fault_in(mezz_fault_in),
    .card_detect_done(card_detect_done), .fan_pwm(fan_pwm),
    .app_running(app_running), .fan_fault_flags(fan_fault_flags));
  bmc_host_model #(.BIT_CYC(BC)) host (.ref_clk(ref_clk), .tx_pin(tx_pin),
    .rx_pin(rx_pin));
  always #2 ref_clk = ~ref_clk;
  task automatic err(input string m);
    $display("unexpected at %0t: %s", $time, m);
    err_count++;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
    input string m);
    tests_run++;
    if (got !== exp) err(m);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Read; optional stray address chars before the closing line feed
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] n,
    input string exp, input bit junk);
    int w;
    w = 0;
    host.rx_q.delete();
    host.send_byte({a, 1'b1});
    host.send_byte(n);
    while (host.rx_q.size() < exp.len() && w < 4000) begin
      @(negedge ref_clk);
      w++;
    end
    if (junk) host.send_byte(8'h0d);
    if (junk) host.send_byte(8'h01);
    host.send_char(bmc_pkg::ASCII_LF);
    repeat (2 * CHAR) @(negedge ref_clk);
    tests_run++;
    if (host.rx_q.size() != exp.len()) err("reply length");
    else for (int i = 0; i < exp.len(); i++)
      if (host.rx_q[i] !== exp[i]) err("reply char");
  endtask
  // One-byte write, then the host's quiet time
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.send_byte({a, 1'b0});
    host.send_byte(8'h01);
    host.send_byte(d);
    host.send_char(bmc_pkg::ASCII_LF);
    repeat (WR_GAP) @(negedge ref_clk);
  endtask
  // Count high cycles of the fan output over one period
  task automatic pwm_hi(output int h);
    h = 0;
    repeat (256) begin
      @(negedge ref_clk);
      if (fan_pwm === 1'b1) h++;
    end
  endtask
  // Hang guard, well above the expected run length
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err("timeout");
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    fan_mode_jumper = 1'b1;
    cpu_temp = 8'h00;
    fan_rpm = 16'h0c15;
    fan_fault_event = 1'b0;
    mezz_fault_in = 16'h1234;
    card_detect_done = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (bmc_pkg::BOOT_CYCLES + 10) @(negedge ref_clk);
    chk8({7'h00, app_running}, 8'h01, "boot not done");
    card_detect_done = 1'b1;
    @(negedge ref_clk);
    card_detect_done = 1'b0;
    mezz_fault_in = 16'h0000;
    fan_fault_event = 1'b1;
    @(negedge ref_clk);
    fan_fault_event = 1'b0;
    card_detect_done = 1'b1;
    @(negedge ref_clk);
    card_detect_done = 1'b0;
    $display("test boot done");
    rd_chk(bmc_pkg::ADDR_FAN_SPEED, 8'h03, "150C01", 1'b0);
    rd_chk(7'h20, 8'h01, "00", 1'b0);
    rd_chk(bmc_pkg::ADDR_FAN_FAULT, 8'h00, "", 1'b0);
    rd_chk(bmc_pkg::ADDR_FAN_FAULT, 8'h01, "01", 1'b1);
    $display("test read done");
    wr(bmc_pkg::ADDR_FAULT_CLEAR, 8'h03);
    chk8(fan_fault_flags, 8'h01, "fault lost");
    wr(bmc_pkg::ADDR_FAULT_CLEAR, bmc_pkg::FAULT_CLEAR_CODE);
    chk8(fan_fault_flags, 8'h00, "fault not cleared");
    rd_chk(bmc_pkg::ADDR_FAN_FAULT, 8'h01, "00", 1'b0);
    rd_chk(bmc_pkg::ADDR_MEZZ_FAULT1, 8'h02, "3412", 1'b0);
    chk8(host.frame_err[7:0], 8'h00, "bad frame");
    $display("test fault done");
    fan_mode_jumper = 1'b0;
    repeat (10) @(negedge ref_clk);
    pwm_hi(h0);
    tests_run++;
    if (h0 != 256) err("fan not at full speed");
    fan_mode_jumper = 1'b1;
    cpu_temp = 8'hff;
    repeat (300) @(negedge ref_clk);
    pwm_hi(h1);
    cpu_temp = 8'h00;
    repeat (300) @(negedge ref_clk);
    pwm_hi(h0);
    tests_run++;
    if (h1 <= h0) err("fan duty ignores temperature");
    $display("test fan done");
    print_verdict();
  end
endmodule // bmc_uart_regs_tb
`default_nettype wire
